// ===== pra_regbank.sv
// Purpose: paged register bank behind an Avalon-MM slave
// Assumes: 8-bit registers in the low byte of each 32-bit word
// Notes:   one wait cycle per access, then waitrequest low once
//
// Contract
// - six-bit address reaches 64 registers
// - eight pages of eight, page in top bits
// - page register reachable from every page
// - dedicated bus gives only three pins
// - dedicated paged: page bits over three pins
// - muxed bus gives six bits, paged or linear
// - muxed paged: page bits over low three
// - muxed linear: all six bits direct
// - dynamic bits host written, engine may overwrite
// - command register clears after command completes
// - read-only registers ignore host writes
// - page register at slot zero of each page
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module pra_regbank
  import pra_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        muxed_bus_mode_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             paging_enable_o,
  output logic      [2:0]  page_number_o,
  output logic             cmd_busy_o
);

  typedef struct packed {
    pra_bus_e                   bus;
    logic                       waitreq;
    logic [31:0]                rdata;
    pra_idx_t                   idx;
    logic                       wr;
    logic                       wr_en;
    logic [7:0]                 wdata;
    logic                       paging_enable;
    logic [2:0]                 page_number;
    logic [7:0]                 command;
    logic                       busy;
    logic                       rejected;
    logic                       start;
    logic [1:0]                 mode_sync;
    logic [`PRA_NREG-1:0][7:0]  mem;
  } pra_bank_s;

  pra_bank_s r;
  pra_bank_s next_r;

  pra_cmd_if cmd_bus ();

  pra_cmd_engine u_engine (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cmd     (cmd_bus.engine)
  );

  // host address to register index
  function automatic pra_idx_t form_index(
    input logic       muxed,
    input logic       pg_en,
    input logic [2:0] page,
    input pra_idx_t   host
  );
    pra_idx_t idx;
    idx = host;
    if (!muxed) begin
      // only pins 2..0 exist on this bus
      idx = {page, host[`PRA_SUB_W-1:0]};
    end else if (pg_en) begin
      // bits 5..3 are ignored here
      idx = {page, host[`PRA_SUB_W-1:0]};
    end else begin
      idx = host;
    end
    return idx;
  endfunction

  // access class of a register index
  function automatic pra_cls_e class_of(input pra_idx_t idx);
    pra_cls_e cls;
    cls = PRA_CLS_RW;
    if (idx[`PRA_SUB_W-1:0] == `PRA_PAGE_SLOT) begin
      cls = PRA_CLS_PAGE;
    end else if (idx == `PRA_IDX_CMD) begin
      cls = PRA_CLS_DYN;
    end else if (idx == `PRA_IDX_STATUS || idx == `PRA_IDX_ERROR) begin
      cls = PRA_CLS_RO;
    end else if (idx == `PRA_IDX_TESTSEL) begin
      cls = PRA_CLS_WO;
    end
    return cls;
  endfunction

  // byte seen by a host read
  function automatic logic [7:0] read_byte(
    input pra_bank_s s,
    input pra_idx_t  idx
  );
    logic [7:0] v;
    v = `PRA_RD_UNDEF;
    unique case (class_of(idx))
      PRA_CLS_PAGE: begin
        v[`PRA_PG_EN_BIT]         = s.paging_enable;
        v[`PRA_PG_HI:`PRA_PG_LO]  = s.page_number;
      end
      PRA_CLS_RW: begin
        v = s.mem[idx];
      end
      PRA_CLS_DYN: begin
        v = s.command;
      end
      PRA_CLS_RO: begin
        if (idx == `PRA_IDX_STATUS) begin
          v[`PRA_ST_BUSY_BIT]  = s.busy;
          v[`PRA_ST_MUXED_BIT] = s.mode_sync[1];
        end else begin
          v[`PRA_ER_REJ_BIT] = s.rejected;
        end
      end
      PRA_CLS_WO: begin
        v = `PRA_RD_UNDEF;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    next_r              = r;
    next_r.start        = 1'b0;
    next_r.mode_sync[0] = muxed_bus_mode_i;
    next_r.mode_sync[1] = r.mode_sync[0];

    // engine completion returns the command to idle
    if (cmd_bus.done) begin
      next_r.command = `PRA_CMD_IDLE;
      next_r.busy    = 1'b0;
    end

    unique case (r.bus)
      PRA_BUS_IDLE: begin
        next_r.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          // index formed with the page state now in force
          next_r.idx = form_index(
            r.mode_sync[1],
            r.paging_enable,
            r.page_number,
            avs_address_i[`PRA_BA_HI:`PRA_BA_LO]);
          next_r.wr    = avs_write_i;
          next_r.wr_en = avs_byteenable_i[0];
          next_r.wdata = avs_writedata_i[7:0];
          next_r.rdata = {24'h000000, read_byte(r, form_index(
            r.mode_sync[1],
            r.paging_enable,
            r.page_number,
            avs_address_i[`PRA_BA_HI:`PRA_BA_LO]))};
          next_r.waitreq = 1'b0;
          next_r.bus     = PRA_BUS_ACK;
        end
      end
      PRA_BUS_ACK: begin
        // the master samples waitrequest low at this edge
        next_r.waitreq = 1'b1;
        next_r.bus     = PRA_BUS_IDLE;
        if (r.wr && r.wr_en) begin
          unique case (class_of(r.idx))
            PRA_CLS_PAGE: begin
              // both fields in one access, used from next access
              next_r.paging_enable =
                r.wdata[`PRA_PG_EN_BIT];
              next_r.page_number =
                r.wdata[`PRA_PG_HI:`PRA_PG_LO];
            end
            PRA_CLS_RW: begin
              next_r.mem[r.idx] = r.wdata;
            end
            PRA_CLS_WO: begin
              next_r.mem[r.idx] = r.wdata;
            end
            PRA_CLS_DYN: begin
              if (r.busy && !cmd_bus.done) begin
                // a new command while one runs is refused
                next_r.rejected = 1'b1;
              end else if (r.wdata != `PRA_CMD_IDLE) begin
                next_r.command  = r.wdata;
                next_r.busy     = 1'b1;
                next_r.start    = 1'b1;
                next_r.rejected = 1'b0;
              end else begin
                next_r.command = r.wdata;
              end
            end
            PRA_CLS_RO: begin
              // host writes leave read-only state alone
              next_r.rejected = r.rejected;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r               <= '0;
      r.bus           <= PRA_BUS_IDLE;
      r.waitreq       <= 1'b1;
      r.paging_enable <= `PRA_RST_PG_EN;
      r.page_number   <= `PRA_RST_PAGE;
      r.command       <= `PRA_CMD_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // engine reads the run length but never writes it
  assign cmd_bus.start   = r.start;
  assign cmd_bus.code    = r.command;
  assign cmd_bus.run_len = r.mem[`PRA_IDX_RUNLEN];

  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign paging_enable_o   = r.paging_enable;
  assign page_number_o     = r.page_number;
  assign cmd_busy_o        = r.busy;

endmodule // pra_regbank

// ===== pra_cfg.svh
// Purpose: constants of the paged register addressing block
// Assumes: included by its bare name
// Notes:   register indices are six-bit word indices
`ifndef PRA_CFG_SVH
`define PRA_CFG_SVH

`define PRA_AW            6
`define PRA_NREG          64
`define PRA_SUB_W         3
`define PRA_PAGE_SLOT     3'h0
`define PRA_IDX_CMD       6'h01
`define PRA_IDX_STATUS    6'h03
`define PRA_IDX_ERROR     6'h0a
`define PRA_IDX_RUNLEN    6'h21
`define PRA_IDX_TESTSEL   6'h3f
`define PRA_PG_EN_BIT     7
`define PRA_PG_HI         2
`define PRA_PG_LO         0
`define PRA_ST_BUSY_BIT   0
`define PRA_ST_MUXED_BIT  1
`define PRA_ER_REJ_BIT    0
`define PRA_CMD_IDLE      8'h00
`define PRA_RST_BYTE      8'h00
`define PRA_RST_PAGE      3'h0
`define PRA_RST_PG_EN     1'b0
`define PRA_RD_UNDEF      8'h00
`define PRA_BA_HI         7
`define PRA_BA_LO         2

`endif

// ===== pra_pkg.sv
// Purpose: types of the paged register addressing block
// Assumes: pra_cfg.svh gives the widths
// Notes:   one-hot codes throughout
`include "pra_cfg.svh"
package pra_pkg;

  typedef enum logic [1:0] {
    PRA_BUS_IDLE = 2'b01,
    PRA_BUS_ACK  = 2'b10
  } pra_bus_e;

  typedef enum logic [4:0] {
    PRA_CLS_PAGE = 5'b00001,
    PRA_CLS_RW   = 5'b00010,
    PRA_CLS_DYN  = 5'b00100,
    PRA_CLS_RO   = 5'b01000,
    PRA_CLS_WO   = 5'b10000
  } pra_cls_e;

  typedef logic [`PRA_AW-1:0] pra_idx_t;

endpackage

// ===== pra_cmd_if.sv
// Purpose: command start and completion between bank and engine
// Assumes: one clock domain
// Notes:   start and done are one-cycle pulses
`timescale 1ns/10ps
interface pra_cmd_if;
  logic       start;
  logic [7:0] code;
  logic [7:0] run_len;
  logic       done;
  modport bank   (output start, output code, output run_len, input done);
  modport engine (input start, input code, input run_len, output done);
endinterface

// ===== pra_cmd_engine.sv
// Purpose: runs a written command for a set number of cycles
// Assumes: start only while idle
// Notes:   run length zero counts as one cycle
`timescale 1ns/10ps
module pra_cmd_engine
  import pra_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  pra_cmd_if.engine cmd
);

  typedef struct packed {
    logic       active;
    logic [7:0] cnt;
    logic       done;
  } pra_eng_s;

  pra_eng_s r;
  pra_eng_s next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (cmd.start) begin
      next_r.active = 1'b1;
      next_r.cnt    = cmd.run_len;
    end else if (r.active) begin
      if (r.cnt <= 8'h01) begin
        next_r.active = 1'b0;
        next_r.done   = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cmd.done = r.done;

endmodule // pra_cmd_engine

// ===== pra_regbank_props.sv
// Purpose: bus and page checks of pra_regbank
// Assumes: one clock, synchronous reset
// Notes:   bound from the bench
`timescale 1ns/10ps
module pra_regbank_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        paging_enable_o,
  input wire logic [2:0]  page_number_o,
  input wire logic        cmd_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       pg_wr;
  logic [8:0] busy_cnt;
  // committed write to slot zero of any page
  assign pg_wr = avs_write_i && !avs_waitrequest_o
    && avs_byteenable_i[0] && avs_address_i[4:2] == 3'h0;
  always_ff @(posedge clk_i)
    busy_cnt <= (!rst_n_i || !cmd_busy_o) ? 9'h0 : busy_cnt + 9'h1;
  sequence s_req; $rose(avs_read_i || avs_write_i); endsequence
  sequence s_pgwr; pg_wr; endsequence
  property p_ans; s_req |=> !avs_waitrequest_o; endproperty
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_idle; !(avs_read_i || avs_write_i) |=> avs_waitrequest_o;
  endproperty
  property p_pg; s_pgwr |=> paging_enable_o == $past(avs_writedata_i[7])
    && page_number_o == $past(avs_writedata_i[2:0]); endproperty
  property p_keep; !pg_wr |=> $stable(page_number_o)
    && $stable(paging_enable_o); endproperty
  property p_start; $rose(cmd_busy_o)
    |-> $past(avs_write_i && !avs_waitrequest_o); endproperty
  // busy spans the run length plus two edges, count 256 at most
  property p_len; cmd_busy_o |-> busy_cnt <= 9'h100; endproperty
  property p_hold; !$fell(avs_waitrequest_o) |-> $stable(avs_readdata_o);
  endproperty
  a_ans: assert property (p_ans)
    else $error("late answer");
  a_one: assert property (p_one)
    else $error("long answer");
  a_idle: assert property (p_idle)
    else $error("answer without request");
  a_pg: assert property (p_pg)
    else $error("page write lost");
  a_keep: assert property (p_keep)
    else $error("page moved");
  a_start: assert property (p_start)
    else $error("busy without write");
  a_len: assert property (p_len)
    else $error("command never ends");
  a_hold: assert property (p_hold)
    else $error("read data moved");
endmodule // pra_regbank_props

// ===== pra_host.sv
// Purpose: host master on the Avalon-MM side
// Assumes: called just after a rising edge
// Notes:   released address and data lines show the inverse value
`timescale 1ns/10ps
module pra_host (
  input  wire logic        clk_i,
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  output logic      [7:0]  addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  be_o,
  output logic             tmo_o
);
  initial begin
    {rd_o, wr_o, tmo_o, addr_o, wdata_o, be_o} = '0;
  end
  task automatic acc(input logic w, input logic [5:0] a,
      input logic [7:0] d, input logic b, output logic [7:0] q);
    int n;
    n = 0;
    addr_o  <= {a, 2'h0};
    wdata_o <= {24'h0, d};
    be_o    <= {3'h0, b};
    rd_o    <= !w;
    wr_o    <= w;
    @(posedge clk_i);
    while (wait_i && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = rdata_i[7:0];
    tmo_o   <= wait_i;
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    addr_o  <= ~{a, 2'h0};
    wdata_o <= ~{24'h0, d};
    @(posedge clk_i);
  endtask
endmodule // pra_host

// ===== paged_register_addressing_test.sv
// Purpose: self-checking bench of pra_regbank
// Assumes: host model drives the bus
// Notes:   reads note expected data in a queue
`timescale 1ns/10ps
module paged_register_addressing_test;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        muxed = 1'b0;
  logic        rd, wr, wt, pg_en, busy, tmo;
  logic [31:0] wdata, rdata;
  logic [7:0]  addr, q, r;
  logic [3:0]  be;
  logic [2:0]  page;
  logic [5:0]  a;
  logic [7:0]  expq[$];
  int          bad_count = 0;
  int          checks = 0;
  initial forever #4 clk_i = ~clk_i;
  pra_host host (.clk_i(clk_i), .wait_i(wt), .rdata_i(rdata),
    .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be),
    .tmo_o(tmo));
  pra_regbank DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .muxed_bus_mode_i(muxed), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .paging_enable_o(pg_en), .page_number_o(page), .cmd_busy_o(busy));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [5:0] ad,
      input logic [7:0] d, input logic b);
    if (!w) expq.push_back(d);
    host.acc(w, ad, d, b, q);
    if (tmo) begin
      bad_count++;
      end_sim();
    end
  endtask
  // oldest note against each read answer
  always @(posedge clk_i)
    if (rst_n_i && rd && !wt && expq.size() > 0)
      check(rdata, {24'h0, expq.pop_front()});
  initial begin
    void'($urandom(32'h6255));
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc(1, 6'h00, 8'h82, 1);
    check({28'h0, pg_en, page}, 32'ha);
    r = 8'($urandom);
    acc(1, 6'h05, r, 1);
    acc(1, 6'h00, 8'h05, 1);
    check({28'h0, pg_en, page}, 32'h5);
    acc(0, 6'h00, 8'h05, 1);
    muxed <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc(0, 6'h15, r, 1);
    acc(1, 6'h08, 8'h82, 1);
    acc(0, 6'h3d, r, 1);
    acc(1, 6'h00, 8'h87, 1);
    acc(1, 6'h07, 8'h5a, 1);
    acc(0, 6'h07, 8'h00, 1);
    acc(1, 6'h00, 8'h00, 1);
    acc(1, 6'h03, 8'hff, 1);
    acc(0, 6'h03, 8'h02, 1);
    acc(1, 6'h21, 8'h03, 1);
    acc(1, 6'h01, 8'h0c, 1);
    check({31'h0, busy}, 32'h1);
    acc(1, 6'h01, 8'h0d, 1);
    acc(0, 6'h0a, 8'h01, 1);
    acc(0, 6'h01, 8'h00, 1);
    acc(0, 6'h21, 8'h03, 1);
    for (int i = 0; i < 6; i++) begin
      a = {3'h5, 3'($urandom_range(7, 1))};
      r = 8'($urandom);
      acc(1, a, r, 1);
      acc(1, a, ~r, 0);
      acc(0, a, r, 1);
    end
    check(32'(expq.size()), 32'h0);
    end_sim();
  end
endmodule // paged_register_addressing_test
bind pra_regbank pra_regbank_props u_props (
  .clk_i             (clk_i),
  .rst_n_i           (rst_n_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_writedata_i   (avs_writedata_i),
  .avs_byteenable_i  (avs_byteenable_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .paging_enable_o   (paging_enable_o),
  .page_number_o     (page_number_o),
  .cmd_busy_o        (cmd_busy_o)
);
